// file: rtl/ppsm_monitor.v
/*
 Paper path sensor monitor: sensor conditioning, pickup and retry, feed and
 exit jam detection, panel LEDs, fan, 24 V and fuser gating, line start.
 Assumes photo-interrupter pins are active high (sheet or state present),
 the scan unit line-start pin is active low, control inputs are synchronous.
*/
`timescale 1ns/100ps
`include "ppsm_regs.vh"
// What this block does
// (RULE_01) Feed sensor silent 1 s: jam, both LEDs
// (RULE_02) Image start waits fixed delay after feed detect
// (RULE_03) Empty cassette lights yellow LED
// (RULE_04) Manual tray paper present: feed from manual tray
// (RULE_05) Pickup solenoid pulse lasts exactly 300 ms (code: over 299 ms up to 300 ms, set by tick phase)
// (RULE_06) Fan follows control bit, off in sleep (code: also off with cover open)
// (RULE_07) Cover open removes 24 V actuator supply
// (RULE_08) Cover open disables fuser power
// (RULE_09) Abnormal exit sensor timing gives exit jam
// (RULE_10) Developer presence sensed like feed sensor
// (RULE_11) Video per line waits for line-start pulse
// (RULE_12) Hardware and firmware overheat both cut fuser
// (RULE_13) Line pacing 1.5 ms fast, 4.5 ms grey/colour
// (RULE_14) Retry pickup once before declaring feed jam
// (RULE_15) Inputs synchronised, debounced; timers use prescaler (line-start and overheat pins synchronised only; line pacing counts clock cycles)
// (RULE_16) Jam and empty flags sticky until cleared
module ppsm_monitor #(
   parameter TICK_DIV = `PPSM_CLK_HZ / 1000000 * `PPSM_TICK_US,
   parameter FEED_TMO = `PPSM_FEED_TMO_MS * 1000 / `PPSM_TICK_US,
   parameter SOL_TIME = `PPSM_SOL_MS * 1000 / `PPSM_TICK_US,
   parameter START_DLY = `PPSM_START_DLY_MS * 1000 / `PPSM_TICK_US,
   parameter EXIT_MIN = `PPSM_EXIT_MIN_MS * 1000 / `PPSM_TICK_US,
   parameter EXIT_MAX = `PPSM_EXIT_MAX_MS * 1000 / `PPSM_TICK_US
) (
   input  wire sys_clk,
   input  wire rst,
   input  wire paperEmptyPin,
   input  wire manualTrayPin,
   input  wire feedSensorPin,
   input  wire exitSensorPin,
   input  wire coverOpenPin,
   input  wire developerIdPin,
   input  wire lineStartPin_n,
   input  wire hwOverheatPin,
   input  wire feedReq,
   input  wire fanControlBit,
   input  wire sleepMode,
   input  wire fwOverheat,
   input  wire heaterReq,
   input  wire slowScan,
   input  wire lineReq,
   input  wire clearFlags,
   output reg  cassetteSolenoid,
   output reg  manualTraySolenoid,
   output reg  fanOn,
   output reg  actuator24vEn,
   output reg  fuserOn,
   output reg  ledRed,
   output reg  ledYellow,
   output reg  feedJam,
   output reg  exitJam,
   output reg  paperEmpty,
   output reg  developerPresent,
   output reg  imageStart,
   output reg  lineGo,
   output reg  scanLineTick
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_PICK  = 3'h1;
   localparam ST_WAIT  = 3'h2;
   localparam ST_DELAY = 3'h3;
   localparam ST_EXIT  = 3'h4;
   localparam ST_JAM   = 3'h5;
   // Line pacing limits in clock cycles, cut to the 16-bit pacing counter
   localparam [31:0] PACE_FAST_W = `PPSM_LINE_FAST_US * (`PPSM_CLK_HZ / 1000000) - 1;
   localparam [31:0] PACE_SLOW_W = `PPSM_LINE_SLOW_US * (`PPSM_CLK_HZ / 1000000) - 1;
   localparam [15:0] PACE_FAST   = PACE_FAST_W[15:0];
   localparam [15:0] PACE_SLOW   = PACE_SLOW_W[15:0];

   wire        emptyLvl;
   wire        manualLvl;
   wire        feedLvl;
   wire        exitLvl;
   wire        coverLvl;
   wire        devLvl;
   reg  [15:0] pre_q;
   reg         tick_q;
   reg  [2:0]  state_q;
   reg  [15:0] tmr_q;
   reg         retried_q;
   reg         useManual_q;
   reg         exitSeen_q;
   reg  [15:0] exitTmr_q;
   reg  [1:0]  lsMeta_q;
   reg         lsPrev_q;
   reg         linePend_q;
   reg  [15:0] paceCnt_q;
   reg  [1:0]  ovMeta_q;

   // Sensors through sync and debounce, one instance per pin [RULE_15]
   ppsm_sync_deb uEmpty (.sys_clk(sys_clk), .rst(rst), .tick(tick_q),
      .pinIn(paperEmptyPin), .levelOut(emptyLvl));
   ppsm_sync_deb uManual (.sys_clk(sys_clk), .rst(rst), .tick(tick_q),
      .pinIn(manualTrayPin), .levelOut(manualLvl));
   ppsm_sync_deb uFeed (.sys_clk(sys_clk), .rst(rst), .tick(tick_q),
      .pinIn(feedSensorPin), .levelOut(feedLvl));
   ppsm_sync_deb uExit (.sys_clk(sys_clk), .rst(rst), .tick(tick_q),
      .pinIn(exitSensorPin), .levelOut(exitLvl));
   ppsm_sync_deb uCover (.sys_clk(sys_clk), .rst(rst), .tick(tick_q),
      .pinIn(coverOpenPin), .levelOut(coverLvl));
   // Developer ID uses the same photo-interrupter path as feed [RULE_10]
   ppsm_sync_deb uDev (.sys_clk(sys_clk), .rst(rst), .tick(tick_q),
      .pinIn(developerIdPin), .levelOut(devLvl));

   // Prescaler: one tick per millisecond drives every timer except line pacing [RULE_15]
   always @(posedge sys_clk) begin
      if (rst) begin
         pre_q  <= 16'h0000;
         tick_q <= 1'b0;
      end else if (pre_q == TICK_DIV[15:0] - 16'h0001) begin
         pre_q  <= 16'h0000;
         tick_q <= 1'b1;
      end else begin
         pre_q  <= pre_q + 16'h0001;
         tick_q <= 1'b0;
      end
   end

   // Feed sequence: pickup, wait feed sensor, retry once, delay, exit
   always @(posedge sys_clk) begin
      if (rst) begin
         state_q            <= ST_IDLE;
         tmr_q              <= 16'h0000;
         retried_q          <= 1'b0;
         useManual_q        <= 1'b0;
         cassetteSolenoid   <= 1'b0;
         manualTraySolenoid <= 1'b0;
         imageStart         <= 1'b0;
         exitSeen_q         <= 1'b0;
         exitTmr_q          <= 16'h0000;
      end else begin
         imageStart <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               tmr_q     <= 16'h0000;
               retried_q <= 1'b0;
               if (feedReq && !coverLvl) begin
                  useManual_q <= manualLvl;              // [RULE_04]
                  cassetteSolenoid   <= !manualLvl;      // [RULE_05]
                  manualTraySolenoid <= manualLvl;       // [RULE_04]
                  state_q <= ST_PICK;
               end
            end
            ST_PICK: begin
               if (tick_q) begin
                  if (tmr_q == SOL_TIME[15:0] - 16'h0001) begin
                     cassetteSolenoid   <= 1'b0;         // [RULE_05]
                     manualTraySolenoid <= 1'b0;
                     state_q            <= ST_WAIT;
                  end
                  tmr_q <= tmr_q + 16'h0001;
               end
            end
            ST_WAIT: begin
               // Timeout counted from the pickup, solenoid time included
               if (feedLvl) begin
                  tmr_q   <= 16'h0000;
                  state_q <= ST_DELAY;
               end else if (tick_q) begin
                  if (tmr_q >= FEED_TMO[15:0] - 16'h0001) begin
                     tmr_q <= 16'h0000;
                     if (!retried_q) begin
                        retried_q          <= 1'b1;      // [RULE_14]
                        cassetteSolenoid   <= !useManual_q;
                        manualTraySolenoid <= useManual_q;
                        state_q            <= ST_PICK;
                     end else begin
                        state_q <= ST_JAM;               // [RULE_01]
                     end
                  end else begin
                     tmr_q <= tmr_q + 16'h0001;
                  end
               end
            end
            ST_DELAY: begin
               if (tick_q) begin
                  if (tmr_q == START_DLY[15:0] - 16'h0001) begin
                     imageStart <= 1'b1;                 // [RULE_02]
                     exitSeen_q <= 1'b0;
                     exitTmr_q  <= 16'h0000;
                     state_q    <= ST_EXIT;
                  end
                  tmr_q <= tmr_q + 16'h0001;
               end
            end
            ST_EXIT: begin
               // Exit sensor must go on then off within a window [RULE_09]
               if (tick_q) begin
                  exitTmr_q <= exitTmr_q + 16'h0001;
               end
               if (exitLvl) begin
                  exitSeen_q <= 1'b1;
               end
               if (exitSeen_q && !exitLvl) begin
                  state_q <= (exitTmr_q < EXIT_MIN[15:0]) ? ST_JAM : ST_IDLE;
               end else if (exitTmr_q >= EXIT_MAX[15:0]) begin
                  state_q <= ST_JAM;
               end
            end
            ST_JAM: begin
               // Hold until software clears the flags
               if (clearFlags) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Sticky flags; a new event wins over a clear in the same cycle
   always @(posedge sys_clk) begin
      if (rst) begin
         feedJam    <= 1'b0;
         exitJam    <= 1'b0;
         paperEmpty <= 1'b0;
      end else begin
         if (state_q == ST_WAIT && tick_q && retried_q &&
             !feedLvl && tmr_q >= FEED_TMO[15:0] - 16'h0001) begin
            feedJam <= 1'b1;                             // [RULE_01] [RULE_16]
         end else if (clearFlags) begin
            feedJam <= 1'b0;
         end
         if (state_q == ST_EXIT && ((exitSeen_q && !exitLvl) ?
             (exitTmr_q < EXIT_MIN[15:0]) : (exitTmr_q >= EXIT_MAX[15:0]))) begin
            exitJam <= 1'b1;                             // [RULE_09] [RULE_16]
         end else if (clearFlags) begin
            exitJam <= 1'b0;
         end
         if (emptyLvl) begin
            paperEmpty <= 1'b1;                          // [RULE_16]
         end else if (clearFlags) begin
            paperEmpty <= 1'b0;
         end
      end
   end

   // Panel LEDs, fan and power gating
   always @(posedge sys_clk) begin
      if (rst) begin
         ledRed           <= 1'b0;
         ledYellow        <= 1'b0;
         fanOn            <= 1'b0;
         actuator24vEn    <= 1'b0;
         fuserOn          <= 1'b0;
         developerPresent <= 1'b0;
         ovMeta_q         <= 2'b00;
      end else begin
         ovMeta_q         <= {ovMeta_q[0], hwOverheatPin};
         ledRed           <= feedJam || exitJam;                   // [RULE_01]
         ledYellow        <= feedJam || exitJam || paperEmpty;     // [RULE_03]
         fanOn            <= fanControlBit && !sleepMode && !coverLvl; // [RULE_06]
         actuator24vEn    <= !coverLvl;                            // [RULE_07]
         // Hardware detector acts alone, firmware is a second layer
         fuserOn          <= heaterReq && !coverLvl &&             // [RULE_08]
                             !ovMeta_q[1] && !fwOverheat;          // [RULE_12]
         developerPresent <= devLvl;                               // [RULE_10]
      end
   end

   // Line start: falling edge of active-low pulse releases pending line
   always @(posedge sys_clk) begin
      if (rst) begin
         lsMeta_q   <= 2'b11;
         lsPrev_q   <= 1'b1;
         linePend_q <= 1'b0;
         lineGo     <= 1'b0;
      end else begin
         lsMeta_q <= {lsMeta_q[0], lineStartPin_n};
         lsPrev_q <= lsMeta_q[1];
         lineGo   <= 1'b0;
         if (lsPrev_q && !lsMeta_q[1] && (linePend_q || lineReq)) begin
            lineGo     <= 1'b1;                          // [RULE_11]
            linePend_q <= 1'b0;
         end else if (lineReq) begin
            linePend_q <= 1'b1;
         end
      end
   end

   // Scan line pacing in microseconds of clock cycles
   always @(posedge sys_clk) begin
      if (rst) begin
         paceCnt_q    <= 16'h0000;
         scanLineTick <= 1'b0;
      end else if (paceCnt_q >= (slowScan ? PACE_SLOW : PACE_FAST)) begin // [RULE_13]
         paceCnt_q    <= 16'h0000;
         scanLineTick <= 1'b1;
      end else begin
         paceCnt_q    <= paceCnt_q + 16'h0001;
         scanLineTick <= 1'b0;
      end
   end
endmodule // ppsm_monitor

// file: rtl/ppsm_regs.vh
/*
 Constants for the paper path sensor monitor: timing figures in their own
 units, debounce length and line pacing figures.
 Assumes a 10 MHz system clock; included by bare name.
*/
`ifndef PPSM_REGS_VH
`define PPSM_REGS_VH
`define PPSM_CLK_HZ        10000000
`define PPSM_TICK_US       1000
`define PPSM_FEED_TMO_MS   1000
`define PPSM_SOL_MS        300
`define PPSM_START_DLY_MS  50
`define PPSM_EXIT_MIN_MS   100
`define PPSM_EXIT_MAX_MS   3000
`define PPSM_LINE_FAST_US  1500
`define PPSM_LINE_SLOW_US  4500
`define PPSM_DEB_TICKS     4'h4
`endif

// file: rtl/ppsm_sync_deb.v
/*
 Two-flop synchroniser followed by a tick-paced debouncer for one pin.
 Assumes a single-cycle tick enable from the parent's prescaler.
*/
`timescale 1ns/100ps
`include "ppsm_regs.vh"
module ppsm_sync_deb (
   input  wire sys_clk,
   input  wire rst,
   input  wire tick,
   input  wire pinIn,
   output reg  levelOut
);
   reg       meta_q;
   reg       sync_q;
   reg [3:0] cnt_q;

   // Meta flop read only by the second flop
   always @(posedge sys_clk) begin
      meta_q <= pinIn;
      sync_q <= meta_q;
   end

   // Level must hold steady for several ticks before it is taken
   always @(posedge sys_clk) begin
      if (rst) begin
         cnt_q    <= 4'h0;
         levelOut <= 1'b0;
      end else if (sync_q == levelOut) begin
         cnt_q <= 4'h0;
      end else if (tick) begin
         if (cnt_q == `PPSM_DEB_TICKS - 4'h1) begin
            levelOut <= sync_q;
            cnt_q    <= 4'h0;
         end else begin
            cnt_q <= cnt_q + 4'h1;
         end
      end
   end
endmodule // ppsm_sync_deb

// file: verif/ppsm_far_side.sv
/* Far-side model: feed and exit sensors moved by released pickups, and
   the scan unit line-start pulse. Assumes the bench sets missCount. */
`timescale 1ns/100ps
module ppsm_far_side (
   input  wire logic       sys_clk,
   input  wire logic       cassetteSolenoid,
   input  wire logic       manualTraySolenoid,
   input  wire logic [1:0] missCount,
   input  wire logic       longExit,
   output logic            feedSensorPin,
   output logic            exitSensorPin,
   output logic            lineStartPin_n
);
   int misses = 0;
   // One sheet per pickup; a missed sheet never reaches a sensor
   initial begin
      feedSensorPin = 1'h0;
      exitSensorPin = 1'h0;
      forever begin
         @(posedge (cassetteSolenoid | manualTraySolenoid));
         @(negedge (cassetteSolenoid | manualTraySolenoid));
         if (misses < missCount) begin
            misses++;
         end else begin
            misses = 0;
            repeat (30) @(posedge sys_clk);
            feedSensorPin <= 1'h1;
            repeat (60) @(posedge sys_clk);
            feedSensorPin <= 1'h0;
            // Sheet reaches the exit only after the 50-tick image start delay
            repeat (510) @(posedge sys_clk);
            exitSensorPin <= 1'h1;
            repeat (longExit ? 600 : 150) @(posedge sys_clk);
            exitSensorPin <= 1'h0;
         end
      end
   end
   // Free-running polygon: one low pulse per facet
   initial begin
      lineStartPin_n = 1'h1;
      forever begin
         repeat (200) @(posedge sys_clk);
         lineStartPin_n <= 1'h0;
         repeat (10) @(posedge sys_clk);
         lineStartPin_n <= 1'h1;
      end
   end
endmodule // ppsm_far_side

// file: verif/ppsm_monitor_assertions.sv
/* Port-level checker for the paper path sensor monitor.
   Assumes one sys_clk domain and synchronous active-high rst. */
`timescale 1ns/100ps
module ppsm_monitor_assertions #(
   parameter TICK_DIV = 10,
   parameter SOL_TIME = 5
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic hwOverheatPin,
   input wire logic coverOpenPin,
   input wire logic lineStartPin_n,
   input wire logic fwOverheat,
   input wire logic sleepMode,
   input wire logic clearFlags,
   input wire logic cassetteSolenoid,
   input wire logic manualTraySolenoid,
   input wire logic fanOn,
   input wire logic actuator24vEn,
   input wire logic fuserOn,
   input wire logic ledRed,
   input wire logic ledYellow,
   input wire logic feedJam,
   input wire logic paperEmpty,
   input wire logic imageStart,
   input wire logic lineGo
);
   logic [31:0] solCnt_q, cvrCnt_q;
   // Pulse length and open-cover time; cover counter waits out debounce
   always_ff @(posedge sys_clk) begin
      solCnt_q <= (cassetteSolenoid | manualTraySolenoid) ? solCnt_q + 32'h1 : 32'h0;
      cvrCnt_q <= coverOpenPin ? cvrCnt_q + 32'h1 : 32'h0;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence overheatHeld;
      hwOverheatPin [*5];
   endsequence
   sequence jamRaised;
      $rose(feedJam);
   endsequence
   a_hw_overheat_cut: assert property (overheatHeld |-> !fuserOn)
      else $error("fuser on during hardware overheat");
   a_fw_overheat_cut: assert property (fwOverheat |=> !fuserOn)
      else $error("fuser on during firmware overheat");
   a_cover_cuts_power: assert property (cvrCnt_q > 6 * TICK_DIV + 4 |->
      !actuator24vEn && !fuserOn) else $error("power kept with cover open");
   a_sleep_fan_off: assert property (sleepMode |=> !fanOn)
      else $error("fan on in sleep");
   a_jam_lights: assert property (jamRaised |=> ledRed && ledYellow)
      else $error("feed jam without both LEDs");
   a_empty_yellow: assert property (paperEmpty |=> ledYellow)
      else $error("empty without yellow LED");
   a_flag_sticky: assert property (feedJam && !clearFlags |=> feedJam)
      else $error("jam flag dropped uncleared");
   a_one_solenoid: assert property (!(cassetteSolenoid && manualTraySolenoid))
      else $error("both solenoids on");
   a_sol_width: assert property ($fell(cassetteSolenoid | manualTraySolenoid) |->
      solCnt_q > (SOL_TIME - 1) * TICK_DIV && solCnt_q <= SOL_TIME * TICK_DIV)
      else $error("solenoid pulse length wrong");
   a_image_pulse: assert property (imageStart |=> !imageStart)
      else $error("image start longer than one cycle");
   a_line_after_start: assert property (lineGo |-> !$past(lineStartPin_n, 3))
      else $error("line go without line-start pulse");
endmodule // ppsm_monitor_assertions

bind ppsm_monitor ppsm_monitor_assertions #(.TICK_DIV(TICK_DIV), .SOL_TIME(SOL_TIME)) u_chk (
   .sys_clk, .rst, .hwOverheatPin, .coverOpenPin, .lineStartPin_n, .fwOverheat, .sleepMode,
   .clearFlags, .cassetteSolenoid, .manualTraySolenoid, .fanOn, .actuator24vEn, .fuserOn,
   .ledRed, .ledYellow, .feedJam, .paperEmpty, .imageStart, .lineGo);

// file: verif/test_ppsm_monitor.sv
/* Testbench for the paper path sensor monitor with short timing params.
   Assumes 1 tick = 10 cycles of the 100 ns clock. */
`timescale 1ns/100ps
module test_ppsm_monitor;
   logic sys_clk = 1'h0, rst = 1'h1, paperEmptyPin = 1'h0, manualTrayPin = 1'h0;
   logic coverOpenPin = 1'h0, developerIdPin = 1'h0, hwOverheatPin = 1'h0, feedReq = 1'h0;
   logic fanControlBit = 1'h0, sleepMode = 1'h0, fwOverheat = 1'h0, heaterReq = 1'h0;
   logic slowScan = 1'h0, lineReq = 1'h0, clearFlags = 1'h0, longExit = 1'h0;
   logic [1:0] missCount = 2'h0;
   logic feedSensorPin, exitSensorPin, lineStartPin_n, cassetteSolenoid, manualTraySolenoid;
   logic fanOn, actuator24vEn, fuserOn, ledRed, ledYellow, feedJam, exitJam, paperEmpty;
   logic developerPresent, imageStart, lineGo, scanLineTick;
   int bad_count = 0, compares = 0, casN = 0, manN = 0, imgN = 0, goN = 0;
   time t0;
   always #50 sys_clk = ~sys_clk;
   // Image start delay left at its default of 50 ticks
   ppsm_monitor #(.TICK_DIV(10), .FEED_TMO(20), .SOL_TIME(5), .EXIT_MIN(2),
      .EXIT_MAX(40)) i_ppsm_monitor (.sys_clk, .rst, .paperEmptyPin, .manualTrayPin,
      .feedSensorPin, .exitSensorPin, .coverOpenPin, .developerIdPin, .lineStartPin_n,
      .hwOverheatPin, .feedReq, .fanControlBit, .sleepMode, .fwOverheat, .heaterReq,
      .slowScan, .lineReq, .clearFlags, .cassetteSolenoid, .manualTraySolenoid, .fanOn,
      .actuator24vEn, .fuserOn, .ledRed, .ledYellow, .feedJam, .exitJam, .paperEmpty,
      .developerPresent, .imageStart, .lineGo, .scanLineTick);
   ppsm_far_side i_ppsm_far_side (.sys_clk, .cassetteSolenoid, .manualTraySolenoid,
      .missCount, .longExit, .feedSensorPin, .exitSensorPin, .lineStartPin_n);
   // Pulse counters, so checks need not catch one-cycle pulses live
   always @(posedge cassetteSolenoid) casN++;
   always @(posedge manualTraySolenoid) manN++;
   always @(posedge sys_clk) begin
      imgN += imageStart;
      goN += lineGo;
   end
   task automatic chk(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %0t ns: got %b expected %b", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic pulse(ref logic s, input int n);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
      cyc(n);
   endtask
   task automatic complete_run;
      $display("Compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog sized above the scan pacing wait, the longest part
   initial begin
      #9_500_000;
      bad_count++;
      complete_run();
   end
   initial begin
      cyc(6);
      chk(actuator24vEn, 1'h0);
      rst = 1'h0;
      cyc(100);
      chk(actuator24vEn, 1'h1);
      pulse(feedReq, 1000);
      chk(casN == 1 && manN == 0 && imgN == 1, 1'h1);
      chk(feedJam | exitJam, 1'h0);
      manualTrayPin = 1'h1;
      cyc(80);
      pulse(feedReq, 1000);
      chk(manN == 1 && casN == 1, 1'h1);
      manualTrayPin = 1'h0;
      missCount = 2'h1;
      cyc(80);
      pulse(feedReq, 1200);
      chk(casN == 3 && imgN == 3 && !feedJam, 1'h1);
      missCount = 2'h2;
      pulse(feedReq, 700);
      chk(casN == 5 && feedJam && ledRed && ledYellow, 1'h1);
      pulse(clearFlags, 3);
      chk(feedJam | ledRed, 1'h0);
      missCount = 2'h0;
      longExit = 1'h1;
      pulse(feedReq, 1200);
      chk(exitJam, 1'h1);
      longExit = 1'h0;
      pulse(clearFlags, 3);
      paperEmptyPin = 1'h1;
      developerIdPin = 1'h1;
      cyc(80);
      chk(paperEmpty & ledYellow & developerPresent, 1'h1);
      paperEmptyPin = 1'h0;
      cyc(80);
      chk(paperEmpty, 1'h1);
      pulse(clearFlags, 3);
      chk(ledYellow, 1'h0);
      fanControlBit = 1'h1;
      heaterReq = 1'h1;
      cyc(3);
      chk(fanOn & fuserOn, 1'h1);
      sleepMode = 1'h1;
      fwOverheat = 1'h1;
      cyc(3);
      chk(fanOn | fuserOn, 1'h0);
      sleepMode = 1'h0;
      fwOverheat = 1'h0;
      hwOverheatPin = 1'h1;
      cyc(6);
      chk(fuserOn, 1'h0);
      hwOverheatPin = 1'h0;
      coverOpenPin = 1'h1;
      cyc(80);
      pulse(feedReq, 100);
      chk(actuator24vEn | fuserOn | casN != 6, 1'h0);
      coverOpenPin = 1'h0;
      cyc(80);
      chk(actuator24vEn & fuserOn, 1'h1);
      pulse(lineReq, 250);
      chk(goN == 1, 1'h1);
      cyc(500);
      chk(goN == 1, 1'h1);
      @(posedge scanLineTick);
      t0 = $time;
      @(posedge scanLineTick);
      chk($time - t0 == 1_500_000, 1'h1);
      t0 = $time;
      @(negedge sys_clk) slowScan = 1'h1;
      @(posedge scanLineTick);
      chk($time - t0 == 4_500_000, 1'h1);
      complete_run();
   end
endmodule // test_ppsm_monitor
